// [hw/bit_sync.sv]
// Two flip-flop level synchroniser, one chain per bit.
`timescale 1ns/100ps
module bit_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// Clock, reset, enable
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic stage1;
			logic stage2;
			always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					stage1 <= RESET_VALUE[i];
					stage2 <= RESET_VALUE[i];
				end else if (ce_in) begin
					stage1 <= async_in[i];
					stage2 <= stage1;
				end
			end
			assign sync_out[i] = stage2;
		end
	endgenerate

endmodule

// [hw/spi_register_datagram_port.sv]
// Slave serial port exchanging 40-bit register datagrams with a host.
//
// Summary of operation
// - Each frame: address byte plus four data bytes.
// - Full 32-bit data field on every access.
// - Bit 39 chooses write; seven address bits follow.
// - Reply of 40 bits shifted every frame.
// - After read, reply carries addressed register.
// - After write, reply echoes written data.
// - Read frames never modify the register.
// - Reply bits 39..32 carry the status byte.
// - Status captured at access end, sent next.
// - Status bits 7,6 are limit-switch stops.
// - Status bits 5,4 are target reached flags.
// - Status bits 3,2 are standstill and stall.
// - Status bits 1,0 from global status word.
// - Values right-aligned in the 32-bit field.
// - Sample on rising, drive after falling, MSB first.
// - Last 40 bits before select rise form command.
// - Excess bits reappear after 40-clock delay.
`timescale 1ns/100ps
module spi_register_datagram_port (
	// System clock, reset, enable
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	// Serial link pins
	input wire logic link_sck_in,
	input wire logic port_select_n_pin_in,
	input wire logic sdi_in,
	output logic sdo_out,
	output logic sdo_oe_out,
	// Register file access
	output logic [spi_dgram_pkg::ADDR_BITS-1:0] reg_addr_out,
	output logic [spi_dgram_pkg::DATA_BITS-1:0] reg_wdata_out,
	output logic reg_write_out,
	output logic reg_read_out,
	input wire logic [spi_dgram_pkg::DATA_BITS-1:0] reg_rdata_in,
	// Status sources
	input wire logic [spi_dgram_pkg::MOTION_W-1:0] motion_status_in,
	input wire logic [31:0] power_stage_status_word_in,
	input wire logic [spi_dgram_pkg::GLOBAL_W-1:0] global_status_word_in,
	// Frame events
	output logic frame_done_out,
	output logic short_frame_out
);

	// **********************************************
	// Link domain: shift register on the serial clock
	// **********************************************
	logic [spi_dgram_pkg::COUNT_W-1:0] bit_count;
	logic [spi_dgram_pkg::FRAME_BITS-1:0] shift_word;
	logic frame_full;
	logic sdo_bit;
	logic [spi_dgram_pkg::FRAME_BITS-1:0] reply_word;
	wire first_bit = (bit_count == '0);
	wire count_last = (bit_count == spi_dgram_pkg::COUNT_LAST);
	wire count_sat = (bit_count == spi_dgram_pkg::COUNT_SAT);

	// The select pin clears the count without a clock edge, because the
	// serial clock stands still between frames.
	always_ff @(posedge link_sck_in or posedge port_select_n_pin_in) begin
		if (port_select_n_pin_in) begin
			bit_count <= '0;
		end else if (!count_sat) begin
			bit_count <= bit_count + 6'h01;
		end
	end

	// The reply is loaded with the first sampled bit, so every later bit
	// in slides through all 40 stages before it reaches the output.
	always_ff @(posedge link_sck_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			shift_word <= spi_dgram_pkg::REPLY_RESET;
		end else if (first_bit) begin
			shift_word <= {reply_word[spi_dgram_pkg::FRAME_BITS-2:0], sdi_in};
		end else begin
			shift_word <= {shift_word[spi_dgram_pkg::FRAME_BITS-2:0], sdi_in};
		end
	end

	always_ff @(posedge link_sck_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			frame_full <= 1'b0;
		end else if (first_bit) begin
			frame_full <= 1'b0;
		end else if (count_last) begin
			frame_full <= 1'b1;
		end
	end

	always_ff @(negedge link_sck_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sdo_bit <= 1'b0;
		end else begin
			sdo_bit <= shift_word[spi_dgram_pkg::FRAME_BITS-1];
		end
	end

	// Bit 39 must be valid before the first rising edge, when no edge has
	// yet moved the shifter, so it is taken from the reply word itself.
	assign sdo_out = first_bit ? reply_word[spi_dgram_pkg::DIR_BIT] : sdo_bit;
	assign sdo_oe_out = !port_select_n_pin_in;

	// **********************************************
	// System domain: frame end detection
	// **********************************************
	logic select_sync;
	logic select_prev;
	wire select_rise = select_sync && !select_prev;

	bit_sync #(
		.WIDTH(1),
		.RESET_VALUE(1'b1)
	) u_select_sync (
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.ce_in(ce_in),
		.async_in(port_select_n_pin_in),
		.sync_out(select_sync)
	);

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			select_prev <= 1'b1;
		end else if (ce_in) begin
			select_prev <= select_sync;
		end
	end

	// **********************************************
	// System domain: commit sequencer
	// **********************************************
	// The shifter and its full flag are only read after the select has
	// settled high; they stay still then because the host stops the clock.
	spi_dgram_pkg::commit_state_t state;
	spi_dgram_pkg::commit_state_t next_state;
	logic [spi_dgram_pkg::FRAME_BITS-1:0] frame_word;
	logic frame_ok;
	logic [spi_dgram_pkg::DATA_BITS-1:0] reply_data;
	logic [7:0] status_now;

	wire frame_is_write = frame_word[spi_dgram_pkg::DIR_BIT];
	wire [spi_dgram_pkg::ADDR_BITS-1:0] frame_addr =
		frame_word[spi_dgram_pkg::ADDR_MSB:spi_dgram_pkg::ADDR_LSB];
	wire [spi_dgram_pkg::DATA_BITS-1:0] frame_data =
		frame_word[spi_dgram_pkg::DATA_BITS-1:0];

	always_comb begin
		next_state = state;
		unique case (state)
			spi_dgram_pkg::ST_IDLE: begin
				if (select_rise) begin
					next_state = spi_dgram_pkg::ST_DECODE;
				end
			end
			spi_dgram_pkg::ST_DECODE: begin
				if (!frame_ok) begin
					next_state = spi_dgram_pkg::ST_IDLE;
				end else if (frame_is_write) begin
					next_state = spi_dgram_pkg::ST_STATUS;
				end else begin
					next_state = spi_dgram_pkg::ST_FETCH;
				end
			end
			spi_dgram_pkg::ST_FETCH: begin
				next_state = spi_dgram_pkg::ST_STATUS;
			end
			spi_dgram_pkg::ST_STATUS: begin
				next_state = spi_dgram_pkg::ST_IDLE;
			end
			default: begin
				next_state = spi_dgram_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= spi_dgram_pkg::ST_IDLE;
		end else if (ce_in) begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			frame_word <= spi_dgram_pkg::REPLY_RESET;
			frame_ok <= 1'b0;
		end else if (ce_in && state == spi_dgram_pkg::ST_IDLE && select_rise) begin
			frame_word <= shift_word;
			frame_ok <= frame_full;
		end
	end

	wire decode_now = (state == spi_dgram_pkg::ST_DECODE) && frame_ok;

	// Register access strobes last one cycle each; a read never writes.
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reg_write_out <= 1'b0;
			reg_read_out <= 1'b0;
			reg_addr_out <= '0;
			reg_wdata_out <= spi_dgram_pkg::DATA_RESET;
		end else if (ce_in) begin
			reg_write_out <= decode_now && frame_is_write;
			reg_read_out <= decode_now && !frame_is_write;
			if (decode_now) begin
				reg_addr_out <= frame_addr;
				reg_wdata_out <= frame_data;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reply_data <= spi_dgram_pkg::DATA_RESET;
		end else if (ce_in) begin
			if (decode_now && frame_is_write) begin
				reply_data <= frame_data;
			end else if (state == spi_dgram_pkg::ST_FETCH) begin
				reply_data <= reg_rdata_in;
			end
		end
	end

	status_byte_builder u_status (
		.motion_status_in(motion_status_in),
		.power_stage_status_word_in(power_stage_status_word_in),
		.global_status_word_in(global_status_word_in),
		.status_byte_out(status_now)
	);

	// The reply word only changes between frames, so the link side may
	// read it without a handshake as long as the host keeps select high
	// for the few system cycles the sequencer needs.
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reply_word <= spi_dgram_pkg::REPLY_RESET;
		end else if (ce_in && state == spi_dgram_pkg::ST_STATUS) begin
			reply_word <= {status_now, reply_data};
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			frame_done_out <= 1'b0;
			short_frame_out <= 1'b0;
		end else if (ce_in) begin
			frame_done_out <= state == spi_dgram_pkg::ST_STATUS;
			short_frame_out <= (state == spi_dgram_pkg::ST_DECODE) && !frame_ok;
		end
	end

endmodule

// [hw/status_byte_builder.sv]
// Assembles the eight status flags returned at the head of every reply.
`timescale 1ns/100ps
module status_byte_builder (
	// Status sources
	input wire logic [spi_dgram_pkg::MOTION_W-1:0] motion_status_in,
	input wire logic [31:0] power_stage_status_word_in,
	input wire logic [spi_dgram_pkg::GLOBAL_W-1:0] global_status_word_in,
	// Assembled byte
	output logic [7:0] status_byte_out
);

	assign status_byte_out[spi_dgram_pkg::ST_STOP_RIGHT] =
		motion_status_in[spi_dgram_pkg::SRC_STOP_RIGHT];
	assign status_byte_out[spi_dgram_pkg::ST_STOP_LEFT] =
		motion_status_in[spi_dgram_pkg::SRC_STOP_LEFT];
	assign status_byte_out[spi_dgram_pkg::ST_POS_REACHED] =
		motion_status_in[spi_dgram_pkg::SRC_POS_REACHED];
	assign status_byte_out[spi_dgram_pkg::ST_VEL_REACHED] =
		motion_status_in[spi_dgram_pkg::SRC_VEL_REACHED];
	assign status_byte_out[spi_dgram_pkg::ST_STANDSTILL] =
		power_stage_status_word_in[spi_dgram_pkg::SRC_STANDSTILL];
	assign status_byte_out[spi_dgram_pkg::ST_LOAD_STALL] =
		power_stage_status_word_in[spi_dgram_pkg::SRC_LOAD_STALL];
	assign status_byte_out[spi_dgram_pkg::ST_DRIVER_ERROR] =
		global_status_word_in[spi_dgram_pkg::SRC_DRIVER_ERROR];
	assign status_byte_out[spi_dgram_pkg::ST_RESET_FLAG] =
		global_status_word_in[spi_dgram_pkg::SRC_RESET_FLAG];

endmodule

// [inc/spi_dgram_pkg.sv]
// Shared constants and types for the serial register datagram port.
package spi_dgram_pkg;

	// **********************************************
	// Datagram layout
	// **********************************************
	localparam int FRAME_BITS = 40;
	localparam int DATA_BITS = 32;
	localparam int ADDR_BITS = 7;
	localparam int STATUS_BITS = 8;
	localparam int COUNT_W = 6;
	localparam logic [5:0] COUNT_LAST = 6'h27;
	localparam logic [5:0] COUNT_SAT = 6'h28;
	localparam int DIR_BIT = 39;
	localparam int ADDR_MSB = 38;
	localparam int ADDR_LSB = 32;

	// **********************************************
	// Reset values
	// **********************************************
	localparam logic [39:0] REPLY_RESET = 40'h00_0000_0000;
	localparam logic [31:0] DATA_RESET = 32'h0000_0000;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// **********************************************
	// Status byte positions and their source bits
	// **********************************************
	localparam int ST_STOP_RIGHT = 7;
	localparam int ST_STOP_LEFT = 6;
	localparam int ST_POS_REACHED = 5;
	localparam int ST_VEL_REACHED = 4;
	localparam int ST_STANDSTILL = 3;
	localparam int ST_LOAD_STALL = 2;
	localparam int ST_DRIVER_ERROR = 1;
	localparam int ST_RESET_FLAG = 0;
	localparam int SRC_STOP_RIGHT = 1;
	localparam int SRC_STOP_LEFT = 0;
	localparam int SRC_POS_REACHED = 9;
	localparam int SRC_VEL_REACHED = 8;
	localparam int SRC_STANDSTILL = 31;
	localparam int SRC_LOAD_STALL = 24;
	localparam int SRC_DRIVER_ERROR = 1;
	localparam int SRC_RESET_FLAG = 0;
	localparam int MOTION_W = 10;
	localparam int GLOBAL_W = 2;

	// **********************************************
	// Commit sequencer states
	// **********************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DECODE = 3'b001,
		ST_FETCH = 3'b010,
		ST_STATUS = 3'b011
	} commit_state_t;

endpackage

// [testbench/link_host_model.sv]
// Host-side serial master that drives mode 3 frames into the port.
`timescale 1ns/100ps
module link_host_model (
	// Serial link
	output logic sck_out,
	output logic select_n_out,
	output logic sdi_out,
	input wire logic sdo_in
);
	initial begin
		sck_out = 1'b1;
		select_n_out = 1'b1;
		sdi_out = 1'b0;
	end
	// The clock stands high between frames; data idles at the inverse of its last bit so a stale read shows.
	// The serial clock outruns half the system clock; that is safe only because the shifter runs on the
	// serial clock itself and the system clock samples only select until select has settled high, and select stays high for many cycles.
	task automatic xfer(input logic [79:0] tx, input int n, output logic [79:0] rx);
		rx = '0;
		select_n_out = 1'b0;
		#5;
		for (int i = n - 1; i >= 0; i--) begin
			sck_out = 1'b0;
			sdi_out = tx[i];
			#3;
			rx = {rx[78:0], sdo_in};
			sck_out = 1'b1;
			#3;
		end
		#5;
		select_n_out = 1'b1;
		sdi_out = ~sdi_out;
	endtask
endmodule

// [testbench/spi_register_datagram_port_props.sv]
// Concurrent checks on the pins of the serial register datagram port.
`timescale 1ns/100ps
module spi_register_datagram_port_props (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	// Watched pins
	input wire logic port_select_n_pin_in,
	input wire logic sdo_oe_out,
	input wire logic [spi_dgram_pkg::ADDR_BITS-1:0] reg_addr_out,
	input wire logic [spi_dgram_pkg::DATA_BITS-1:0] reg_wdata_out,
	input wire logic reg_write_out,
	input wire logic reg_read_out,
	input wire logic frame_done_out,
	input wire logic short_frame_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!arst_n_in);
	// ********************************
	// Assertions
	// ********************************
	a_strobe_exclusive: assert property (reg_read_out |-> !reg_write_out)
		else $error("read and write strobes together");
	a_write_single: assert property (reg_write_out |=> !reg_write_out)
		else $error("write strobe longer than one cycle");
	a_read_single: assert property (reg_read_out |=> !reg_read_out)
		else $error("read strobe longer than one cycle");
	a_write_done: assert property (reg_write_out |-> ##1 frame_done_out)
		else $error("no reply update one cycle after write");
	a_read_done: assert property (reg_read_out |-> ##2 frame_done_out)
		else $error("no reply update two cycles after read");
	a_done_cause: assert property ($rose(frame_done_out) |-> $past(reg_write_out) || $past(reg_read_out, 2))
		else $error("reply update without an access");
	a_oe_select: assert property (sdo_oe_out == !port_select_n_pin_in)
		else $error("output enable does not follow select");
	a_short_quiet: assert property (short_frame_out |-> ##1 (!reg_write_out && !reg_read_out && !frame_done_out) [*3])
		else $error("access after a short frame");
	a_wdata_held: assert property (reg_write_out |=> $stable(reg_wdata_out) [*3])
		else $error("write data not held");
	a_addr_held: assert property (frame_done_out |-> $stable(reg_addr_out))
		else $error("address moved at reply update");
	c_write: cover property (reg_write_out);
	c_read: cover property (reg_read_out);
	c_short: cover property (short_frame_out);
endmodule

bind spi_register_datagram_port spi_register_datagram_port_props i_props (
	.clk_sys_in(clk_sys_in),
	.arst_n_in(arst_n_in),
	.port_select_n_pin_in(port_select_n_pin_in),
	.sdo_oe_out(sdo_oe_out),
	.reg_addr_out(reg_addr_out),
	.reg_wdata_out(reg_wdata_out),
	.reg_write_out(reg_write_out),
	.reg_read_out(reg_read_out),
	.frame_done_out(frame_done_out),
	.short_frame_out(short_frame_out)
);

// [testbench/tb_spi_register_datagram_port.sv]
// Self-checking bench for the serial register datagram port.
`timescale 1ns/100ps
module tb_spi_register_datagram_port;
	logic clk_sys_in;
	logic arst_n_in;
	logic ce_in;
	logic sck;
	logic sel_n;
	logic sdi;
	logic sdo_out;
	logic sdo_oe_out;
	logic [spi_dgram_pkg::ADDR_BITS-1:0] reg_addr_out;
	logic [spi_dgram_pkg::DATA_BITS-1:0] reg_wdata_out;
	logic reg_write_out;
	logic reg_read_out;
	logic frame_done_out;
	logic short_frame_out;
	logic [9:0] motion;
	logic [31:0] power;
	logic [1:0] glob;
	logic [7:0] st;
	logic [7:0] sa;
	logic [79:0] rx;
	int bad_count = 0;
	int check_count = 0;
	int n_wr = 0;
	int n_rd = 0;
	int n_short = 0;
	wire sdo_line = sdo_oe_out ? sdo_out : 1'bz;
	wire [31:0] rdata = {4{1'b0, reg_addr_out}};
	spi_register_datagram_port i_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .ce_in(ce_in),
		.link_sck_in(sck), .port_select_n_pin_in(sel_n), .sdi_in(sdi), .sdo_out(sdo_out),
		.sdo_oe_out(sdo_oe_out), .reg_addr_out(reg_addr_out), .reg_wdata_out(reg_wdata_out),
		.reg_write_out(reg_write_out), .reg_read_out(reg_read_out), .reg_rdata_in(rdata),
		.motion_status_in(motion), .power_stage_status_word_in(power), .global_status_word_in(glob),
		.frame_done_out(frame_done_out), .short_frame_out(short_frame_out));
	link_host_model i_host (.sck_out(sck), .select_n_out(sel_n), .sdi_out(sdi), .sdo_in(sdo_line));
	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in) begin
		n_wr += reg_write_out;
		n_rd += reg_read_out;
		n_short += short_frame_out;
	end
	// ********************************
	// Tasks
	// ********************************
	task automatic check_val(input logic [39:0] act, input logic [39:0] exp);
		check_count++;
		if (act !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, act, exp);
		end
	endtask
	task automatic set_st(input logic [9:0] m, input logic [31:0] p, input logic [1:0] g);
		@(posedge clk_sys_in);
		motion <= m;
		power <= p;
		glob <= g;
		st = {m[1], m[0], m[9], m[8], p[31], p[24], g[1], g[0]};
	endtask
	task automatic frame(input logic [79:0] tx, input int n);
		int i;
		i_host.xfer(tx, n, rx);
		for (i = 0; i < 40 && frame_done_out !== 1'b1 && short_frame_out !== 1'b1; i++)
			@(negedge clk_sys_in);
		if (i == 40) begin
			bad_count++;
			$display("unexpected at %0t: no frame event", $time);
		end
		repeat (10) @(negedge clk_sys_in);
		$display("frame of %0d bits done", n);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#20000;
		bad_count++;
		end_of_test();
	end
	// ********************************
	// Tests
	// ********************************
	initial begin
		arst_n_in = 1'b0;
		ce_in = 1'b1;
		motion = '0;
		power = '0;
		glob = '0;
		repeat (2) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		set_st(10'h301, 32'h0100_0000, 2'b10);
		sa = st;
		frame({40'h0, 8'h80 + 8'h27, 32'h00ab_cdef}, 40);
		check_val(rx[39:0], 40'h0);
		check_val(40'(n_wr), 40'h1);
		check_val(40'(reg_addr_out), 40'h27);
		check_val(40'(reg_wdata_out), 40'h00ab_cdef);
		frame({8'h21, 32'hffff_ffff}, 40);
		check_val(rx[39:0], {sa, 32'h00ab_cdef});
		check_val(40'({n_wr, n_rd}), 40'({32'h1, 32'h1}));
		set_st(10'h002, 32'h8000_0000, 2'b01);
		frame({8'h05, 32'h0}, 40);
		check_val(rx[39:0], {sa, 32'h2121_2121});
		frame({8'h5a, 8'h90, 32'h1122_3344}, 48);
		check_val(rx[47:8], {st, 32'h0505_0505});
		check_val(40'(rx[7:0]), 40'h5a);
		check_val({1'b0, reg_addr_out, reg_wdata_out}, {8'h10, 32'h1122_3344});
		frame(80'h81_2345, 24);
		check_val(40'({n_short, n_wr, n_rd}), 40'({32'h1, 32'h2, 32'h2}));
		frame({8'h00, 32'h0}, 40);
		check_val(rx[39:0], {st, 32'h1122_3344});
		// A frame sent while the clock enable is low is never seen by the sequencer.
		@(posedge clk_sys_in);
		ce_in <= 1'b0;
		@(negedge clk_sys_in);
		i_host.xfer({40'h0, 8'h85, 32'hdead_beef}, 40, rx);
		repeat (12) @(posedge clk_sys_in);
		ce_in <= 1'b1;
		check_val(rx[39:0], {st, 32'h0000_0000});
		check_val(40'(n_wr), 40'h2);
		$display("frame with clock enable low done");
		frame({8'h00, 32'h0}, 40);
		check_val(rx[39:0], {st, 32'h0000_0000});
		end_of_test();
	end
endmodule
